// ### logic/edge_sync.sv
// Two-stage synchroniser with edge detection for a group of pins.
// Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module edge_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0 // Idle pin levels held in reset
) (
  input wire logic clk_i, // System clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic [W-1:0] in_i, // Raw pin levels
  input wire logic [W-1:0] rst_val_i, // Unused-safe reset image, tied constant
  output logic [W-1:0] lvl_o, // Synchronised level
  output logic [W-1:0] rise_o, // One-cycle rise pulse
  output logic [W-1:0] fall_o // One-cycle fall pulse
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;

  sync_t q, d;

  // Only s2 reads s1; edges come from s2 against s3
  always_comb
  begin
    d = q;
    d.s1 = in_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  // Reset to idle pin levels so no false edge follows release
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q <= {RST_VAL, RST_VAL, RST_VAL};
    else
      q <= d;
  end

  assign lvl_o = q.s2 | (rst_val_i & ~rst_val_i);
  assign rise_o = q.s2 & ~q.s3;
  assign fall_o = ~q.s2 & q.s3;

endmodule : edge_sync
`default_nettype wire

// ### logic/interval_timer.sv
// Down-counting interval timer with a one-cycle expiry pulse.
// Assumes load values of at least one cycle.
`timescale 1ns/1ns
`default_nettype none
module interval_timer #(
  parameter int W = 16
) (
  input wire logic clk_i, // System clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic start_i, // Restart with load_i
  input wire logic [W-1:0] load_i, // Interval in cycles
  output logic busy_o, // Counting
  output logic done_o // Expiry pulse
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } tmr_t;

  tmr_t q, d;

  // Restart wins over expiry so a new interval never misfires
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (start_i)
      d.cnt = load_i;
    else if (q.cnt != '0)
    begin
      d.cnt = q.cnt - 1'b1;
      d.done = (q.cnt == W'(1));
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q <= '0;
    else
      q <= d;
  end

  assign busy_o = (q.cnt != '0);
  assign done_o = q.done;

endmodule : interval_timer
`default_nettype wire

// ### logic/opstate_pkg.sv
// Shared types and constants for the radio operating-state controller.
// Assumes a single 125 MHz system clock drives all design logic.
package opstate_pkg;

  // ***********************************
  // Clock and timing
  // ***********************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_SETTLE_NS = 128000;
  localparam int STAB_NS = 256000;
  localparam int RAMP_NS = 16000;
  // Least times round up to whole cycles
  localparam int CLK_SETTLE_CYC = (CLK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_CYC = (STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_CYC = (RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 16;
  localparam logic [5:0] CLK_STOP_CYCLES = 6'd35;

  // ***********************************
  // Register map and SPI framing
  // ***********************************
  localparam logic [5:0] ADDR_STATUS = 6'h01;
  localparam logic [5:0] ADDR_CMD = 6'h02;
  localparam logic [5:0] ADDR_CLKCTL = 6'h03;
  localparam int SPI_ACC_BIT = 7;
  localparam int SPI_WR_BIT = 6;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CLKCTL_RESET = 8'h01;
  localparam int CLKSEL_W = 2;

  // Command codes in the state command register
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_TX_START = 8'h02;
  localparam logic [7:0] CMD_FORCE_IDLE = 8'h03;
  localparam logic [7:0] CMD_LISTEN = 8'h06;
  localparam logic [7:0] CMD_IDLE = 8'h08;
  localparam logic [7:0] CMD_SYNTH_ON = 8'h09;

  // Status codes in the state status register
  localparam logic [7:0] STS_POWER_ON = 8'h00;
  localparam logic [7:0] STS_LISTEN = 8'h06;
  localparam logic [7:0] STS_IDLE = 8'h08;
  localparam logic [7:0] STS_SYNTH_ON = 8'h09;
  localparam logic [7:0] STS_RECEIVING = 8'h01;
  localparam logic [7:0] STS_TRANSMITTING = 8'h02;
  localparam logic [7:0] STS_SLEEP = 8'h0f;
  localparam logic [7:0] STS_CLOCKLESS = 8'h1c;
  localparam logic [7:0] STS_IN_TRANSITION = 8'h1f;

  // Controller clock periods in system cycles: off, 1, 2, 4 MHz
  localparam logic [7:0] CLKDIV_1MHZ = 8'd125;
  localparam logic [7:0] CLKDIV_2MHZ = 8'd62;
  localparam logic [7:0] CLKDIV_4MHZ = 8'd31;

  // ***********************************
  // Types
  // ***********************************
  typedef enum logic [3:0] {
    S_POWER_ON, S_SLEEP, S_WAKE_CLK, S_WAKE_STAB, S_IDLE,
    S_SYNTH_ON, S_LISTEN, S_RECEIVING, S_TRANSMITTING, S_CLOCKLESS
  } op_state_t;

  typedef struct packed {
    logic preamble;
    logic frame_done;
    logic tx_done;
    logic pll_lock;
  } radio_evt_t;

  typedef struct packed {
    logic osc;
    logic avreg;
    logic synth;
    logic rx;
    logic digrx;
    logic pa;
  } ana_ctrl_t;

  typedef struct packed {
    logic lock;
    logic frame_start;
    logic frame_end;
  } irq_t;

  // Controller clock period for a select value, zero means off
  function automatic logic [7:0] clk_div(input logic [CLKSEL_W-1:0] sel);
    logic [7:0] d;
    unique case (sel)
      2'd1: d = CLKDIV_1MHZ;
      2'd2: d = CLKDIV_2MHZ;
      2'd3: d = CLKDIV_4MHZ;
      default: d = 8'h00;
    endcase
    return d;
  endfunction : clk_div

endpackage : opstate_pkg

// ### logic/radio_operating_state_control.sv
// Operating-state sequencer of a 2.4 GHz transceiver with its SPI registers.
// Assumes analog and modem events arrive on clk_i; pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Power-on: oscillator on, clock after 128us
// - Input pulls enabled only in power-on
// - Leave power-on only on idle command write
// - Sleep only from idle on pin high
// - Pin low in sleep wakes, registers kept
// - Reset pin in sleep: defaults, then idle
// - Regulator, then synthesizer, lock interrupt
// - Listen command works before synthesizer lock
// - Listen command from idle enables receiver
// - Listen: preamble detect starts receiving
// - Trigger pin ignored while receiving
// - Pin rise in listen: clockless, stop 35
// - Clockless frame: start irq, clock, end irq
// - Re-enter clockless only after low-high
// - Pin low in clockless resumes listen, clock
// - Transmit from synth-on by pin or command
// - First preamble chip delayed 16us
// - After last bit, amplifier off, synth-on
// - Pin-started transmit needs low then high
// - Wake: clock after settle, 256us, idle
// - Regulator ramp then 16us before synthesizer
// - Current state readable in status register
// - Force idle aborts; plain idle waits frame
// - Reset pin outside power-on: defaults, idle
module radio_operating_state_control
  import opstate_pkg::*;
#(
  parameter int CLK_SETTLE_CYCLES = opstate_pkg::CLK_SETTLE_CYC,
  parameter int STAB_CYCLES = opstate_pkg::STAB_CYC
) (
  input wire logic clk_i, // 125 MHz system clock
  input wire logic rstn_i, // Power-on reset, active low
  input wire logic spi_sclk_i, // SPI clock pin
  input wire logic spi_sel_n_i, // SPI select, active low
  input wire logic spi_mosi_i, // SPI data in
  output logic spi_miso_o, // SPI data out
  output logic spi_miso_oe_o, // SPI data out enable
  input wire logic sleep_transmit_trigger_pin_i, // Sleep / transmit trigger
  input wire logic rst_pin_n_i, // Reset pin, active low
  input wire opstate_pkg::radio_evt_t radio_evt_i, // Modem and synthesizer events
  output opstate_pkg::ana_ctrl_t ana_o, // Analog block enables
  output logic tx_chip_start_o, // First preamble chip pulse
  output logic controller_clock_output_o, // Clock to host controller
  output opstate_pkg::irq_t irq_o, // Interrupt pulses
  output logic pullups_en_o // Input pull resistors enable
);

  // ***********************************
  // Pin synchronisation and timers
  // ***********************************
  logic [4:0] pin_lvl, pin_rise, pin_fall;
  logic sclk_rise, sclk_fall, sel_n, sel_fall, mosi, trig, trig_rise, rst_pin_n;
  logic lt_start, lt_busy, lt_done, st_start, st_busy, st_done;
  logic [TMR_W-1:0] lt_load;

  edge_sync #(.W(5), .RST_VAL(5'h12)) u_sync ( // Select and reset pin idle high
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_i({rst_pin_n_i, sleep_transmit_trigger_pin_i, spi_mosi_i, spi_sel_n_i, spi_sclk_i}),
    .rst_val_i(5'h00),
    .lvl_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign sclk_rise = pin_rise[0];
  assign sclk_fall = pin_fall[0];
  assign sel_n = pin_lvl[1];
  assign sel_fall = pin_fall[1];
  assign mosi = pin_lvl[2];
  assign trig = pin_lvl[3];
  assign trig_rise = pin_rise[3];
  assign rst_pin_n = pin_lvl[4];

  // Long timer: clock settle and stability waits
  interval_timer #(.W(TMR_W)) u_long (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(lt_start),
    .load_i(lt_load),
    .busy_o(lt_busy),
    .done_o(lt_done)
  );

  // Short timer: regulator settle and transmit lead-in
  interval_timer #(.W(TMR_W)) u_short (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(st_start),
    .load_i(TMR_W'(RAMP_CYC)),
    .busy_o(st_busy),
    .done_o(st_done)
  );

  // ***********************************
  // State
  // ***********************************
  typedef struct packed {
    op_state_t st;
    logic boot;
    logic clk_avail;
    logic settled;
    logic tx_wait;
    logic pend_idle;
    logic lock_seen;
    logic [4:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] hdr;
    logic [7:0] rdata;
    logic miso;
    logic [7:0] cmd;
    logic [7:0] clkctl;
    logic [7:0] div_cnt;
    logic [5:0] stop_cnt;
    logic gated;
    logic clk_out;
    logic tx_go;
    irq_t irq;
  } ctl_t;

  ctl_t q, d;
  logic wr_stb, cmd_stb;
  logic [7:0] wdata, div;
  logic clk_run, wrap;

  // Status code of the current state
  function automatic logic [7:0] status_of(input op_state_t s);
    logic [7:0] c;
    unique case (s)
      S_POWER_ON: c = STS_POWER_ON;
      S_SLEEP: c = STS_SLEEP;
      S_IDLE: c = STS_IDLE;
      S_SYNTH_ON: c = STS_SYNTH_ON;
      S_LISTEN: c = STS_LISTEN;
      S_RECEIVING: c = STS_RECEIVING;
      S_TRANSMITTING: c = STS_TRANSMITTING;
      S_CLOCKLESS: c = STS_CLOCKLESS;
      S_WAKE_CLK, S_WAKE_STAB: c = STS_IN_TRANSITION;
    endcase
    return c;
  endfunction : status_of

  // Register read mux; unmapped addresses read zero
  function automatic logic [7:0] reg_read(input logic [5:0] a, input ctl_t s);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_STATUS)
      v = status_of(s.st);
    else if (a == ADDR_CMD)
      v = s.cmd;
    else if (a == ADDR_CLKCTL)
      v = s.clkctl;
    return v;
  endfunction : reg_read

  // Write strobe at the sixteenth rising SPI clock of a write frame
  assign wr_stb = sclk_rise && !sel_n && (q.bit_cnt == 5'd15)
                  && q.hdr[SPI_ACC_BIT] && q.hdr[SPI_WR_BIT];
  assign wdata = {q.shift[6:0], mosi};
  assign cmd_stb = wr_stb && (q.hdr[5:0] == ADDR_CMD);
  assign div = clk_div(q.clkctl[CLKSEL_W-1:0]);
  assign clk_run = q.clk_avail && !q.gated && (div != 8'h00);
  assign wrap = clk_run && (q.div_cnt == div - 8'd1);
  assign lt_load = (q.st == S_WAKE_CLK) ? TMR_W'(STAB_CYCLES) : TMR_W'(CLK_SETTLE_CYCLES);

  // ***********************************
  // Next-state logic
  // ***********************************
  always_comb
  begin
    d = q;
    d.irq = '0;
    d.tx_go = 1'b0;
    lt_start = 1'b0;
    st_start = 1'b0;

    // SPI slave, mode 0, header byte then data byte
    if (sel_fall || sel_n)
      d.bit_cnt = 5'd0;
    else if (sclk_rise)
    begin
      d.shift = {q.shift[6:0], mosi};
      d.bit_cnt = (q.bit_cnt == 5'd15) ? 5'd0 : q.bit_cnt + 5'd1;
      if (q.bit_cnt == 5'd7)
      begin
        d.hdr = {q.shift[6:0], mosi};
        d.rdata = reg_read(d.hdr[5:0], q);
      end
    end
    if (sclk_fall && !sel_n && q.bit_cnt >= 5'd8)
      d.miso = q.rdata[3'(5'd15 - q.bit_cnt)];
    if (wr_stb && q.st != S_SLEEP)
    begin
      if (q.hdr[5:0] == ADDR_CMD)
        d.cmd = wdata;
      else if (q.hdr[5:0] == ADDR_CLKCTL)
        d.clkctl = wdata;
    end

    // Controller clock divider, cleared while stopped and at each wrap
    if (!clk_run || wrap)
      d.div_cnt = 8'h00;
    else
      d.div_cnt = q.div_cnt + 8'd1;
    d.clk_out = clk_run && (d.div_cnt < {1'b0, div[7:1]});
    if (q.st == S_CLOCKLESS && !q.gated && wrap)
    begin
      d.stop_cnt = q.stop_cnt - 6'd1;
      d.gated = (q.stop_cnt == 6'd1);
    end
    // Cut the last period at once so no runt pulse reaches the host
    if (d.gated)
      d.clk_out = 1'b0;

    // Regulator settle and transmit lead-in
    if (st_done)
    begin
      d.settled = 1'b1;
      if (q.st == S_TRANSMITTING && q.tx_wait)
      begin
        d.tx_wait = 1'b0;
        d.tx_go = 1'b1;
      end
    end

    // Lock interrupt once per synthesizer enable
    if (ana_o.synth && radio_evt_i.pll_lock && !q.lock_seen)
    begin
      d.lock_seen = 1'b1;
      d.irq.lock = 1'b1;
    end
    if (!ana_o.synth)
      d.lock_seen = 1'b0;

    // Operating-state sequencer
    unique case (q.st)
      S_POWER_ON:
      begin
        if (!q.boot)
        begin
          d.boot = 1'b1;
          lt_start = 1'b1;
        end
        if (lt_done)
          d.clk_avail = 1'b1;
        if (q.clk_avail && cmd_stb && (wdata == CMD_IDLE || wdata == CMD_FORCE_IDLE))
          d.st = S_IDLE;
      end
      S_SLEEP:
        if (!trig)
        begin
          d.st = S_WAKE_CLK;
          lt_start = 1'b1;
        end
      S_WAKE_CLK:
        if (lt_done)
        begin
          d.clk_avail = 1'b1;
          d.st = S_WAKE_STAB;
          lt_start = 1'b1;
        end
      S_WAKE_STAB:
        if (lt_done)
          d.st = S_IDLE;
      S_IDLE:
        if (cmd_stb && (wdata == CMD_SYNTH_ON || wdata == CMD_LISTEN))
        begin
          d.st = (wdata == CMD_LISTEN) ? S_LISTEN : S_SYNTH_ON;
          d.settled = 1'b0;
          st_start = 1'b1;
        end
        else if (trig)
        begin
          d.st = S_SLEEP;
          d.clk_avail = 1'b0;
        end
      S_SYNTH_ON:
        if (cmd_stb && wdata == CMD_LISTEN)
          d.st = S_LISTEN;
        else if (cmd_stb && (wdata == CMD_IDLE || wdata == CMD_FORCE_IDLE))
          d.st = S_IDLE;
        else if (trig_rise || (cmd_stb && wdata == CMD_TX_START))
        begin
          d.st = S_TRANSMITTING;
          d.tx_wait = 1'b1;
          st_start = 1'b1;
        end
      S_LISTEN:
        if (cmd_stb && wdata == CMD_SYNTH_ON)
          d.st = S_SYNTH_ON;
        else if (cmd_stb && (wdata == CMD_IDLE || wdata == CMD_FORCE_IDLE))
          d.st = S_IDLE;
        else if (radio_evt_i.preamble)
        begin
          d.st = S_RECEIVING;
          d.irq.frame_start = 1'b1;
        end
        else if (trig_rise)
        begin
          d.st = S_CLOCKLESS;
          d.stop_cnt = CLK_STOP_CYCLES;
        end
      S_CLOCKLESS:
        if (cmd_stb && (wdata == CMD_IDLE || wdata == CMD_FORCE_IDLE))
        begin
          d.st = S_IDLE;
          d.gated = 1'b0;
        end
        else if (radio_evt_i.preamble)
        begin
          d.st = S_RECEIVING;
          d.irq.frame_start = 1'b1;
          d.gated = 1'b0;
        end
        else if (!trig)
        begin
          d.st = S_LISTEN;
          d.gated = 1'b0;
        end
      S_RECEIVING:
        if (cmd_stb && wdata == CMD_FORCE_IDLE)
          d.st = S_IDLE;
        else if (radio_evt_i.frame_done)
        begin
          d.irq.frame_end = 1'b1;
          d.st = q.pend_idle ? S_IDLE : S_LISTEN;
          d.pend_idle = 1'b0;
        end
        else if (cmd_stb && wdata == CMD_IDLE)
          d.pend_idle = 1'b1;
      S_TRANSMITTING:
        if (cmd_stb && wdata == CMD_FORCE_IDLE)
        begin
          d.st = S_IDLE;
          d.tx_wait = 1'b0;
        end
        else if (radio_evt_i.tx_done && !q.tx_wait)
        begin
          d.irq.frame_end = 1'b1;
          d.st = q.pend_idle ? S_IDLE : S_SYNTH_ON;
          d.pend_idle = 1'b0;
        end
        else if (cmd_stb && wdata == CMD_IDLE)
          d.pend_idle = 1'b1;
    endcase
    if (d.st == S_IDLE)
    begin
      d.pend_idle = 1'b0;
      d.gated = 1'b0;
    end

    // Reset pin: defaults and idle, ignored during power-on
    if (!rst_pin_n && q.st != S_POWER_ON)
    begin
      d.st = S_IDLE;
      d.cmd = CMD_RESET;
      d.clkctl = CLKCTL_RESET;
      d.clk_avail = 1'b1;
      d.gated = 1'b0;
      d.pend_idle = 1'b0;
      d.tx_wait = 1'b0;
      d.settled = 1'b0;
    end
  end

  // ***********************************
  // Registers
  // ***********************************
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q <= '0;
      q.st <= S_POWER_ON;
      q.cmd <= CMD_RESET;
      q.clkctl <= CLKCTL_RESET;
    end
    else
      q <= d;
  end

  // ***********************************
  // Outputs
  // ***********************************
  // Analog enables decoded from the registered state
  always_comb
  begin
    ana_o = '0;
    ana_o.osc = (q.st != S_SLEEP);
    ana_o.avreg = q.st inside {S_SYNTH_ON, S_LISTEN, S_RECEIVING, S_TRANSMITTING, S_CLOCKLESS};
    ana_o.synth = ana_o.avreg && q.settled;
    ana_o.rx = q.st inside {S_LISTEN, S_RECEIVING, S_CLOCKLESS};
    ana_o.digrx = (q.st == S_RECEIVING);
    ana_o.pa = (q.st == S_TRANSMITTING) && !q.tx_wait;
  end

  assign pullups_en_o = (q.st == S_POWER_ON);
  assign tx_chip_start_o = q.tx_go;
  assign controller_clock_output_o = q.clk_out;
  assign irq_o = q.irq;
  assign spi_miso_o = q.miso;
  assign spi_miso_oe_o = !sel_n;

endmodule : radio_operating_state_control
`default_nettype wire

// ### verification/host_spi_model.sv
// Host controller model: SPI master of 16-bit frames, mode 0.
// Assumes the caller enters xfer just after a clk_i edge.
`timescale 1ns/1ns
`default_nettype none
module host_spi_model (
  input wire logic clk_i, // System clock
  input wire logic spi_miso_i, // Device data out
  input wire logic spi_miso_oe_i, // Device drives data out
  output logic spi_sclk_o, // SPI clock, still outside frames
  output logic spi_sel_n_o, // Select, active low
  output logic spi_mosi_o // Data to device
);
  localparam int HALF = 5; // 40 ns half of the 80 ns link clock
  logic miso_w;
  logic last_q;
  initial
  begin
    spi_sclk_o = 1'b0;
    spi_sel_n_o = 1'b1;
    spi_mosi_o = 1'b0;
    last_q = 1'b0;
  end
  // A released line shows the inverse of its last driven bit
  assign miso_w = spi_miso_oe_i ? spi_miso_i : !last_q;
  always @(posedge clk_i) if (spi_miso_oe_i) last_q <= spi_miso_i;
  // Header byte then data byte, MSB first; read bits taken at rises
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {hdr, wd};
    rd = 8'h00;
    @(posedge clk_i);
    spi_sel_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_mosi_o <= sh[i];
      spi_sclk_o <= 1'b0;
      repeat (HALF) @(posedge clk_i);
      spi_sclk_o <= 1'b1;
      if (i < 8) rd[i] = miso_w;
      repeat (HALF) @(posedge clk_i);
    end
    spi_sclk_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
    spi_sel_n_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
  endtask : xfer
endmodule : host_spi_model
`default_nettype wire

// ### verification/radio_operating_state_control_chk.sv
// Port-level checks of the operating-state controller.
// Assumes it is bound into the design top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module radio_operating_state_control_chk
  import opstate_pkg::*;
#(
  parameter int CLK_SETTLE_CYCLES = opstate_pkg::CLK_SETTLE_CYC,
  parameter int STAB_CYCLES = opstate_pkg::STAB_CYC
) (
  input wire logic clk_i, // System clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic rst_pin_n_i, // Reset pin, active low
  input wire opstate_pkg::radio_evt_t radio_evt_i, // Modem events
  input wire opstate_pkg::ana_ctrl_t ana_o, // Analog enables
  input wire logic tx_chip_start_o, // First chip pulse
  input wire logic controller_clock_output_o, // Host clock
  input wire opstate_pkg::irq_t irq_o, // Interrupt pulses
  input wire logic pullups_en_o // Pull enable
);
  int settle_q;
  int ramp_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Reset pin skips the settle wait, so it fills the counter
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      settle_q <= 0;
      ramp_q <= 0;
    end
    else
    begin
      settle_q <= !rst_pin_n_i ? CLK_SETTLE_CYCLES : (!ana_o.osc ? 0 :
                  (settle_q < CLK_SETTLE_CYCLES ? settle_q + 1 : settle_q));
      ramp_q <= !ana_o.avreg ? 0 : (ramp_q < RAMP_CYC ? ramp_q + 1 : ramp_q);
    end
  end
  sequence s_tx_end;
    radio_evt_i.tx_done && ana_o.pa;
  endsequence
  sequence s_pa_up;
    tx_chip_start_o ##[0:1] ana_o.pa;
  endsequence
  a_clock_after_settle: assert property (controller_clock_output_o |-> settle_q == CLK_SETTLE_CYCLES)
    else $error("host clock before settling");
  a_ramp_before_synth: assert property ($rose(ana_o.synth) |-> ramp_q >= RAMP_CYC - 2)
    else $error("synthesizer on before ramp");
  a_lock_cause: assert property (irq_o.lock |-> $past(radio_evt_i.pll_lock) && $past(ana_o.synth))
    else $error("lock irq without lock");
  a_pulls_stay_off: assert property (!pullups_en_o |=> !pullups_en_o)
    else $error("pulls enabled again");
  a_chip_with_pa: assert property (tx_chip_start_o |-> s_pa_up)
    else $error("chip start without amplifier");
  a_pa_off_end: assert property (s_tx_end |-> ##[1:2] !ana_o.pa)
    else $error("amplifier left on");
  a_start_cause: assert property (irq_o.frame_start |-> $past(radio_evt_i.preamble) && $past(ana_o.rx))
    else $error("frame start irq without preamble");
  a_end_cause: assert property (irq_o.frame_end |-> $past(radio_evt_i.frame_done) || $past(radio_evt_i.tx_done))
    else $error("frame end irq without end");
  a_digrx_in_rx: assert property (ana_o.digrx |-> ana_o.rx && !ana_o.pa)
    else $error("digital receiver outside receive");
  a_pa_not_rx: assert property (ana_o.pa |-> ana_o.synth && !ana_o.rx)
    else $error("amplifier outside transmit");
endmodule : radio_operating_state_control_chk
bind radio_operating_state_control radio_operating_state_control_chk #(
  .CLK_SETTLE_CYCLES(CLK_SETTLE_CYCLES),
  .STAB_CYCLES(STAB_CYCLES)
) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .rst_pin_n_i(rst_pin_n_i), .radio_evt_i(radio_evt_i), .ana_o(ana_o),
  .tx_chip_start_o(tx_chip_start_o), .controller_clock_output_o(controller_clock_output_o), .irq_o(irq_o),
  .pullups_en_o(pullups_en_o)
);
`default_nettype wire

// ### verification/test_radio_operating_state_control.sv
// Self-checking bench of the operating-state controller.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_radio_operating_state_control;
  import opstate_pkg::*;
  logic clk_i, rstn_i, sclk, sel_n, mosi, miso, miso_oe, pin, rst_pin_n, cko, chip, pulls;
  radio_evt_t evt;
  ana_ctrl_t ana;
  irq_t irq;
  int mismatches, cmp_count, c;
  logic [7:0] rd;
  initial clk_i = 1'b0;
  always #4 clk_i = ~clk_i;
  // Short settle counts keep the run brief
  radio_operating_state_control #(.CLK_SETTLE_CYCLES(20), .STAB_CYCLES(30)) DUT (
    .clk_i(clk_i), .rstn_i(rstn_i), .spi_sclk_i(sclk), .spi_sel_n_i(sel_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .sleep_transmit_trigger_pin_i(pin), .rst_pin_n_i(rst_pin_n),
    .radio_evt_i(evt), .ana_o(ana), .tx_chip_start_o(chip), .controller_clock_output_o(cko), .irq_o(irq),
    .pullups_en_o(pulls));
  host_spi_model host (.clk_i(clk_i), .spi_miso_i(miso), .spi_miso_oe_i(miso_oe), .spi_sclk_o(sclk),
    .spi_sel_n_o(sel_n), .spi_mosi_o(mosi));
  // ***********************************
  // Access and compare tasks
  // ***********************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer({2'b11, a}, d, rd);
  endtask : wr
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    host.xfer({2'b10, a}, 8'h00, rd);
    chk(rd, exp);
  endtask : rdchk
  task automatic sts(input logic [7:0] exp);
    rdchk(ADDR_STATUS, exp);
  endtask : sts
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  // Event bit 3 preamble, 2 frame done, 1 transmit done
  task automatic pulse(input int k);
    evt[k] <= 1'b1;
    @(posedge clk_i);
    evt[k] <= 1'b0;
    @(posedge clk_i);
    chk({5'h00, irq}, (k == 3) ? 8'h02 : 8'h01);
    cyc(4);
  endtask : pulse
  task automatic rises(input int n);
    logic prev;
    c = 0;
    prev = cko;
    repeat (n)
    begin
      @(posedge clk_i);
      if (cko === 1'b1 && prev === 1'b0) c++;
      prev = cko;
    end
  endtask : rises
  // Trigger pin falls while reset holds, so sleep is not re-entered
  task automatic rst_pulse;
    rst_pin_n <= 1'b0;
    cyc(5);
    pin <= 1'b0;
    cyc(5);
    rst_pin_n <= 1'b1;
    cyc(10);
  endtask : rst_pulse
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // Guard against a hang
  initial
  begin
    cyc(90000);
    mismatches++;
    test_done;
  end
  // Main sequence
  initial
  begin
    rstn_i = 1'b0;
    pin = 1'b0;
    rst_pin_n = 1'b1;
    evt = '0;
    mismatches = 0;
    cmp_count = 0;
    cyc(3);
    rstn_i <= 1'b1;
    chk({7'h00, pulls}, 8'h01);
    rises(300);
    chk(8'(c > 1), 8'h01);
    sts(STS_POWER_ON);
    rdchk(ADDR_CLKCTL, CLKCTL_RESET);
    wr(ADDR_CMD, CMD_IDLE);
    sts(STS_IDLE);
    chk({7'h00, pulls}, 8'h00);
    $display("test power_on done");
    wr(ADDR_CLKCTL, 8'h02);
    pin <= 1'b1;
    cyc(20);
    sts(STS_SLEEP);
    pin <= 1'b0;
    cyc(120);
    sts(STS_IDLE);
    rdchk(ADDR_CLKCTL, 8'h02);
    pin <= 1'b1;
    cyc(20);
    rst_pulse();
    sts(STS_IDLE);
    rdchk(ADDR_CLKCTL, CLKCTL_RESET);
    $display("test sleep done");
    wr(ADDR_CMD, CMD_SYNTH_ON);
    sts(STS_SYNTH_ON);
    cyc(2100);
    evt.pll_lock <= 1'b1;
    cyc(2);
    chk({7'h00, irq.lock}, 8'h01);
    wr(ADDR_CMD, CMD_TX_START);
    sts(STS_TRANSMITTING);
    chk({7'h00, ana.pa}, 8'h00);
    cyc(2000);
    chk({7'h00, ana.pa}, 8'h01);
    pulse(1);
    sts(STS_SYNTH_ON);
    pin <= 1'b1;
    cyc(10);
    sts(STS_TRANSMITTING);
    cyc(2000);
    pulse(1);
    sts(STS_SYNTH_ON);
    pin <= 1'b0;
    cyc(10);
    pin <= 1'b1;
    cyc(10);
    sts(STS_TRANSMITTING);
    pin <= 1'b0;
    evt.pll_lock <= 1'b0;
    wr(ADDR_CMD, CMD_FORCE_IDLE);
    sts(STS_IDLE);
    $display("test transmit done");
    wr(ADDR_CMD, CMD_SYNTH_ON);
    wr(ADDR_CMD, CMD_LISTEN);
    sts(STS_LISTEN);
    pulse(3);
    sts(STS_RECEIVING);
    pin <= 1'b1;
    cyc(10);
    wr(ADDR_CMD, CMD_IDLE);
    sts(STS_RECEIVING);
    pin <= 1'b0;
    pulse(2);
    sts(STS_IDLE);
    $display("test receive done");
    wr(ADDR_CMD, CMD_LISTEN);
    sts(STS_LISTEN);
    pin <= 1'b1;
    rises(6000);
    chk(8'(c >= 34 && c <= 36), 8'h01);
    sts(STS_CLOCKLESS);
    pulse(3);
    sts(STS_RECEIVING);
    pulse(2);
    sts(STS_LISTEN);
    pin <= 1'b0;
    cyc(10);
    pin <= 1'b1;
    cyc(10);
    sts(STS_CLOCKLESS);
    cyc(4500);
    rises(300);
    chk(8'(c), 8'h00);
    pin <= 1'b0;
    rises(400);
    chk(8'(c > 1), 8'h01);
    sts(STS_LISTEN);
    $display("test clockless done");
    rst_pulse();
    sts(STS_IDLE);
    rdchk(ADDR_CMD, CMD_RESET);
    wr(ADDR_STATUS, 8'h55);
    sts(STS_IDLE);
    rdchk(6'h3f, 8'h00);
    $display("test registers done");
    test_done;
  end
endmodule : test_radio_operating_state_control
`default_nettype wire
